// File: design/sensor_pkg.sv
/*
  shared constants and types of the sensor serial slave.
  assumes a 10 MHz system clock.
*/
package sensor_pkg;
  // =====================================================
  // bus address
  localparam logic [6:0] DEV_ADDR = 7'h43;
  // =====================================================
  // register offsets
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h10;
  localparam logic [7:0] OFS_PWR_STAT = 8'h11;
  localparam logic [7:0] OFS_RUN = 8'h21;
  localparam logic [7:0] OFS_START = 8'h22;
  localparam logic [7:0] OFS_STOP = 8'h23;
  localparam logic [7:0] OFS_SENSOR_STATUS = 8'h24;
  localparam logic [7:0] OFS_T_VAL = 8'h30;
  localparam logic [7:0] OFS_H_VAL = 8'h33;
  // =====================================================
  // fields and reset values
  localparam int BIT_LOWPWR = 0;
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h01;
  localparam logic [1:0] SENSOR_MASK = 2'h3;
  // =====================================================
  // timing
  localparam int CLK_MHZ = 10;
  localparam int BOOT_US = 1000;
  localparam int T_CONV_US = 104000;
  localparam int TH_CONV_US = 225000;
  localparam int BOOT_CYC = BOOT_US * CLK_MHZ;
  localparam int T_CONV_CYC = T_CONV_US * CLK_MHZ;
  localparam int TH_CONV_CYC = TH_CONV_US * CLK_MHZ;
  // =====================================================
  // states
  typedef enum logic [1:0] {pwr_off, pwr_booting, pwr_active, pwr_standby} power_state_type;
  typedef enum logic [3:0] {
    bus_idle, bus_addr, bus_addr_ack, bus_ptr, bus_ptr_ack,
    bus_wdata, bus_wdata_ack, bus_rdata, bus_rdata_ack
  } bus_state_type;
endpackage

// File: design/sensor_result_bank.sv
/*
  result memory: one 16-bit entry per sensor, registered read.
  assumes writes and reads on the system clock.
*/
`timescale 1ns/1ps
module sensor_result_bank
  import sensor_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] we_i,
  input wire logic [1:0][15:0] wdata_i,
  input wire logic raddr_i,
  output logic [15:0] rdata_o
);
  logic [1:0][15:0] mem;

  // =====================================================
  // storage
  for (genvar e = 0; e < 2; e++) begin : g_entry
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        mem[e] <= 16'h0000;
      end else if (we_i[e]) begin
        mem[e] <= wdata_i[e];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// File: design/sensor_i2c_register_slave.sv
/*
  serial register slave and power sequencer of the sensor.
  assumes scl/sda synchronous to clock_i, open-drain sda resolved outside.
*/
//
// Operation
// - works at 100 and 400 kbit/s bus rates
// - never holds the clock line low
// - 7-bit addressing only, no optional or master features
// - answers only address 0x43 (0x86 write, 0x87 read)
// - one-byte register addresses and one-byte values
// - write: address byte, pointer byte, both acked, pointer loaded
// - each written byte stored at pointer if writable, pointer then increments
// - writes to reserved or read-only addresses are not acknowledged
// - read returns byte at pointer, then pointer increments
// - 256 addresses, unimplemented ones are reserved
// - reserved addresses read as zero
// - bus fully usable in standby
// - command: standby, booting, active, measure, back to standby
// - continuous mode or low power off keeps sequencer active
// - power-up boots to active then drops to standby
// - booting advances to active automatically, about 1 ms
// - temperature-only conversion within its time limits
// - combined conversion within 238 ms per cycle
// - power status readable through a status register
// - temperature result is a calibrated kelvin value
`timescale 1ns/1ps
module sensor_i2c_register_slave
  import sensor_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_CYC,
  parameter int T_CYCLES = T_CONV_CYC,
  parameter int TH_CYCLES = TH_CONV_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [15:0] temp_data_i,
  input wire logic [15:0] hum_data_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic engine_power_o,
  output logic measure_busy_o
);
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  bus_state_type bus_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx, current_register_pointer, rd_byte;
  logic rd_mode, wr_stb, wr_ok;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] system_control_reg, sensor_run_mode_reg, start_reg, stop_reg;
  power_state_type power_state;
  logic [23:0] cnt;
  logic [1:0] kind, cont, valid, done_clr;
  logic busy, done;
  logic [1:0] bank_we;
  logic [15:0] bank_rdata;

  // =====================================================
  // line sampling
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // edges seen at 10 MHz, ample at 400 kbit/s
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;

  // writable addresses only; others nacked
  always_comb begin
    unique case (current_register_pointer)
      OFS_SYSTEM_CONTROL, OFS_RUN, OFS_START, OFS_STOP: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // =====================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (current_register_pointer)
      OFS_SYSTEM_CONTROL: rd_byte = system_control_reg;
      OFS_PWR_STAT: rd_byte = {7'h00, power_state == pwr_active};
      OFS_RUN: rd_byte = sensor_run_mode_reg;
      OFS_START: rd_byte = start_reg;
      OFS_STOP: rd_byte = stop_reg;
      OFS_SENSOR_STATUS: rd_byte = {6'h00, busy ? kind : 2'h0};
      OFS_T_VAL, OFS_H_VAL: rd_byte = bank_rdata[7:0];
      OFS_T_VAL + 8'h01, OFS_H_VAL + 8'h01: rd_byte = bank_rdata[15:8];
      OFS_T_VAL + 8'h02: rd_byte = {7'h00, valid[0]};
      OFS_H_VAL + 8'h02: rd_byte = {7'h00, valid[1]};
      default: rd_byte = 8'h00;
    endcase
  end

  // =====================================================
  // bus engine: only sda is ever driven, never scl
  always_ff @(posedge clock_i) begin
    wr_stb <= 1'b0;
    if (srst_i) begin
      bus_state <= bus_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rd_mode <= 1'b0;
      sda_oe_o <= 1'b0;
      current_register_pointer <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (start_cond) begin
      bus_state <= bus_addr;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_cond) begin
      bus_state <= bus_idle;
      sda_oe_o <= 1'b0;
    end else begin
      unique case (bus_state)
        bus_idle: sda_oe_o <= 1'b0;
        bus_addr, bus_ptr, bus_wdata: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_i};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (bus_state == bus_addr) begin
              if (shift[7:1] == DEV_ADDR) begin
                bus_state <= bus_addr_ack;
                rd_mode <= shift[0];
                sda_oe_o <= 1'b1;
              end else begin
                bus_state <= bus_idle;
              end
            end else if (bus_state == bus_ptr) begin
              current_register_pointer <= shift;
              bus_state <= bus_ptr_ack;
              sda_oe_o <= 1'b1;
            end else begin
              wr_stb <= wr_ok;
              wr_addr <= current_register_pointer;
              wr_data <= shift;
              current_register_pointer <= current_register_pointer + 8'h01;
              sda_oe_o <= wr_ok;
              bus_state <= bus_wdata_ack;
            end
          end
        end
        bus_addr_ack, bus_rdata_ack: begin
          if (scl_rise && bus_state == bus_rdata_ack && sda_i) begin
            bus_state <= bus_idle;
          end else if (scl_fall) begin
            if (rd_mode) begin
              tx <= {rd_byte[6:0], 1'b0};
              sda_oe_o <= ~rd_byte[7];
              bit_cnt <= 4'h1;
              current_register_pointer <= current_register_pointer + 8'h01;
              bus_state <= bus_rdata;
            end else begin
              sda_oe_o <= 1'b0;
              bit_cnt <= 4'h0;
              bus_state <= bus_ptr;
            end
          end
        end
        bus_ptr_ack, bus_wdata_ack: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            bit_cnt <= 4'h0;
            bus_state <= bus_wdata;
          end
        end
        bus_rdata: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              bus_state <= bus_rdata_ack;
            end else begin
              sda_oe_o <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    sda_o <= 1'b0;
  end

  // =====================================================
  // control registers, set wins over completion clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      system_control_reg <= SYSTEM_CONTROL_RESET;
      sensor_run_mode_reg <= 8'h00;
      start_reg <= 8'h00;
      stop_reg <= 8'h00;
    end else begin
      if (done) begin
        start_reg <= start_reg & ~{6'h00, done_clr};
        stop_reg <= stop_reg & ~{6'h00, done_clr};
      end
      if (wr_stb) begin
        unique case (wr_addr)
          OFS_SYSTEM_CONTROL: system_control_reg <= wr_data;
          OFS_RUN: sensor_run_mode_reg <= wr_data & {6'h00, SENSOR_MASK};
          OFS_START: start_reg <= (done ? start_reg & ~{6'h00, done_clr} : start_reg)
                                  | (wr_data & {6'h00, SENSOR_MASK});
          OFS_STOP: stop_reg <= (done ? stop_reg & ~{6'h00, done_clr} : stop_reg)
                                | (wr_data & {6'h00, SENSOR_MASK});
          default: ;
        endcase
      end
    end
  end

  // =====================================================
  // power sequencer
  always_ff @(posedge clock_i) begin
    done <= 1'b0;
    if (srst_i) begin
      power_state <= pwr_off;
      cnt <= 24'h000000;
      kind <= 2'h0;
      cont <= 2'h0;
      valid <= 2'h0;
      busy <= 1'b0;
      done_clr <= 2'h0;
    end else begin
      unique case (power_state)
        pwr_off: begin
          power_state <= pwr_booting;
          cnt <= 24'h000000;
        end
        pwr_booting: begin
          if (cnt == 24'(BOOT_CYCLES - 1)) begin
            power_state <= pwr_active;
            cnt <= 24'h000000;
          end else begin
            cnt <= cnt + 24'h000001;
          end
        end
        pwr_active: begin
          if (busy) begin
            if (cnt == (kind[1] ? 24'(TH_CYCLES - 1) : 24'(T_CYCLES - 1))) begin
              busy <= 1'b0;
              done <= 1'b1;
              valid <= valid | kind;
              cont <= kind & sensor_run_mode_reg[1:0] & ~stop_reg[1:0];
              done_clr <= kind & ~(sensor_run_mode_reg[1:0] & ~stop_reg[1:0]);
            end else begin
              cnt <= cnt + 24'h000001;
            end
          end else if (start_reg[1:0] != 2'h0 && !done) begin
            busy <= 1'b1;
            kind <= start_reg[1:0];
            cnt <= 24'h000000;
            valid <= valid & ~(start_reg[1:0] & ~cont);
          end else if (!done && system_control_reg[BIT_LOWPWR] && cont == 2'h0) begin
            power_state <= pwr_standby;
          end
        end
        pwr_standby: begin
          cont <= 2'h0;
          if (start_reg[1:0] != 2'h0 || !system_control_reg[BIT_LOWPWR]) begin
            power_state <= pwr_booting;
            cnt <= 24'h000000;
          end
        end
      endcase
    end
  end

  // result capture; temperature arrives calibrated in kelvin
  assign bank_we = (busy && power_state == pwr_active &&
                    cnt == (kind[1] ? 24'(TH_CYCLES - 1) : 24'(T_CYCLES - 1))) ? kind : 2'h0;

  sensor_result_bank u_bank (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .we_i(bank_we),
    .wdata_i({hum_data_i, temp_data_i}),
    .raddr_i(current_register_pointer >= OFS_H_VAL),
    .rdata_o(bank_rdata)
  );

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      engine_power_o <= 1'b0;
      measure_busy_o <= 1'b0;
    end else begin
      engine_power_o <= power_state == pwr_booting || power_state == pwr_active;
      measure_busy_o <= busy;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_byte_in(bus_state_type st);
    bus_state == st && scl_fall && bit_cnt == 4'h8 && !start_cond && !stop_cond;
  endsequence

  property p_drive_window;
    sda_oe_o |-> bus_state inside {bus_addr_ack, bus_ptr_ack, bus_wdata_ack, bus_rdata};
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("sda driven outside ack or data");

  property p_addr_ack;
    s_byte_in(bus_addr) ##0 shift[7:1] == DEV_ADDR |=> sda_oe_o && bus_state == bus_addr_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_foreign;
    s_byte_in(bus_addr) ##0 shift[7:1] != DEV_ADDR |=> !sda_oe_o && bus_state == bus_idle;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address answered");

  property p_ptr_load;
    s_byte_in(bus_ptr) |=> current_register_pointer == $past(shift) && sda_oe_o;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_write_inc;
    s_byte_in(bus_wdata) |=> current_register_pointer == $past(current_register_pointer) + 8'h01
      ##1 wr_addr == $past(current_register_pointer, 2) || bus_state != bus_wdata_ack;
  endproperty
  a_write_inc: assert property (p_write_inc) else $error("pointer not incremented");

  property p_write_nack;
    s_byte_in(bus_wdata) ##0 !wr_ok |=> !sda_oe_o && !wr_stb;
  endproperty
  a_write_nack: assert property (p_write_nack) else $error("reserved write acked");

  property p_boot_len;
    power_state == pwr_booting && cnt == 24'(BOOT_CYCLES - 1) |=> power_state == pwr_active;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("booting did not end");

  property p_power_up;
    power_state == pwr_off |=> power_state == pwr_booting ##1 power_state == pwr_booting;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no boot after power-up");

  property p_stay_active;
    power_state == pwr_active && !busy && cont != 2'h0 |=> power_state == pwr_active;
  endproperty
  a_stay_active: assert property (p_stay_active) else $error("left active in continuous mode");
endmodule

// File: bench/i2c_master_model.sv
/*
  bus master model driving scl and an open-drain sda pull-down.
  assumes sda_i is the resolved wire with a pull-up; steps on the falling clock edge.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // =====================================================
  // bit timing, half a bus period in clocks
  int half = 13;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // =====================================================
  // conditions and bytes
  task automatic start_cond();
    sda_low_o = 1'b0;
    tick(half / 2);
    scl_o = 1'b1;
    tick(half);
    sda_low_o = 1'b1;
    tick(half);
    scl_o = 1'b0;
  endtask
  task automatic put_bit(input logic b, output logic seen);
    tick(half / 2);
    sda_low_o = ~b;
    tick(half / 2);
    scl_o = 1'b1;
    tick(half);
    seen = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(~ack, s);
  endtask
  task automatic stop_cond();
    tick(half / 2);
    sda_low_o = 1'b1;
    tick(half / 2);
    scl_o = 1'b1;
    tick(half);
    sda_low_o = 1'b0;
    tick(half);
  endtask
endmodule

// File: bench/tb_top.sv
/*
  self-checking bench of the sensor serial slave and sequencer.
  assumes the package, the design and the master model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import sensor_pkg::*;
  localparam int BOOT_C = 20;
  localparam int T_C = 50;
  localparam int TH_C = 100;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] temp_data_i = 16'h0000;
  logic [15:0] hum_data_i = 16'h0000;
  logic scl, sda_low, sda_o, sda_oe_o, engine_power_o, measure_busy_o;
  wire logic sda = ~(sda_low | (sda_oe_o & ~sda_o));
  int error_cnt = 0;
  int checks = 0;
  int busy_run = 0;
  int last_busy = 0;
  logic [7:0] ref_mem [256];
  always #50 clock_i = ~clock_i;
  sensor_i2c_register_slave #(.BOOT_CYCLES(BOOT_C), .T_CYCLES(T_C), .TH_CYCLES(TH_C)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .temp_data_i(temp_data_i),
    .hum_data_i(hum_data_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .engine_power_o(engine_power_o),
    .measure_busy_o(measure_busy_o));
  i2c_master_model master (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // =====================================================
  // length of the last measurement step
  always @(negedge clock_i) begin
    if (measure_busy_o === 1'b1) busy_run <= busy_run + 1;
    else if (busy_run != 0) begin
      last_busy <= busy_run;
      busy_run <= 0;
    end
  end
  // =====================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_pwr(input logic v, input int lim, output int n);
    n = 0;
    while (engine_power_o !== v && n < lim) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  function automatic logic wok(input logic [7:0] p);
    return p inside {8'h10, 8'h21, 8'h22, 8'h23};
  endfunction
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic a;
    logic [7:0] q;
    q = p;
    master.start_cond();
    master.send_byte(8'h86, a);
    check(16'(a), 16'h1);
    master.send_byte(p, a);
    check(16'(a), 16'h1);
    foreach (d[i]) begin
      master.send_byte(d[i], a);
      check(16'(a), 16'(wok(q)));
      if (wok(q)) ref_mem[q] = d[i];
      q++;
    end
    master.stop_cond();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic a;
    logic [7:0] b;
    logic [7:0] q;
    q = p;
    master.start_cond();
    master.send_byte(8'h86, a);
    master.send_byte(p, a);
    check(16'(a), 16'h1);
    master.start_cond();
    master.send_byte(8'h87, a);
    check(16'(a), 16'h1);
    for (int i = 0; i < n; i++) begin
      master.recv_byte(i < n - 1, b);
      check(16'(b), 16'(ref_mem[q]));
      q++;
    end
    master.stop_cond();
  endtask
  task automatic foreign(input logic [7:0] b);
    logic a;
    master.start_cond();
    master.send_byte(b, a);
    check(16'(a), 16'h0);
    master.send_byte(8'h10, a);
    check(16'(a), 16'h0);
    master.stop_cond();
  endtask
  task automatic set_results();
    ref_mem[8'h30] = temp_data_i[7:0];
    ref_mem[8'h31] = temp_data_i[15:8];
    ref_mem[8'h32] = 8'h01;
    ref_mem[8'h33] = hum_data_i[7:0];
    ref_mem[8'h34] = hum_data_i[15:8];
    ref_mem[8'h35] = 8'h01;
  endtask
  // =====================================================
  // tests
  initial begin
    int n;
    logic [7:0] r;
    void'($urandom(33));
    foreach (ref_mem[i]) ref_mem[i] = 8'h00;
    ref_mem[8'h10] = SYSTEM_CONTROL_RESET;
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    wait_pwr(1'b1, 20, n);
    check(16'(engine_power_o), 16'h1);
    wait_pwr(1'b0, BOOT_C + 20, n);
    check(16'(engine_power_o), 16'h0);
    check(16'(n >= BOOT_C - 1 && n <= BOOT_C + 4), 16'h1);
    $display("test power-up done");
    master.half = 50;
    rd(8'h0F, 3);
    master.half = 13;
    r = 8'($urandom_range(0, 125));
    if (r >= 8'h43) r++;
    foreign(8'h00);
    foreign(8'hF0);
    foreign({r[6:0], 1'b0});
    $display("test foreign address done");
    wr(8'h0F, {8'($urandom), 8'h00, 8'($urandom)});
    wait_pwr(1'b1, BOOT_C + 20, n);
    check(16'(engine_power_o), 16'h1);
    ref_mem[8'h11] = 8'h01;
    rd(8'h10, 2);
    wr(8'h10, {SYSTEM_CONTROL_RESET});
    wait_pwr(1'b0, 20, n);
    check(16'(engine_power_o), 16'h0);
    ref_mem[8'h11] = 8'h00;
    $display("test write and pointer done");
    foreach (ref_mem[i]) if (i >= 8'h30 && i <= 8'h35) ref_mem[i] = 8'h00;
    for (int k = 1; k <= 3; k += 2) begin
      temp_data_i = 16'($urandom);
      hum_data_i = 16'($urandom);
      wr(8'h22, {8'(k)});
      wait_pwr(1'b0, BOOT_C + TH_C + 50, n);
      check(16'(engine_power_o), 16'h0);
      n = (k == 1) ? T_C : TH_C;
      check(16'(last_busy >= n - 1 && last_busy <= n + 2), 16'h1);
      ref_mem[8'h30] = temp_data_i[7:0];
      ref_mem[8'h31] = temp_data_i[15:8];
      ref_mem[8'h32] = 8'h01;
      if (k == 3) set_results();
      rd(8'h30, 6);
    end
    $display("test single shot done");
    temp_data_i = 16'($urandom);
    wr(8'h21, {8'h01, 8'h01});
    check(16'(engine_power_o), 16'h1);
    wr(8'h23, {8'h01});
    wait_pwr(1'b0, T_C + 50, n);
    check(16'(engine_power_o), 16'h0);
    set_results();
    rd(8'h30, 3);
    ref_mem[8'h22] = 8'h00;
    ref_mem[8'h23] = 8'h00;
    rd(8'h21, 4);
    $display("test continuous done");
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    error_cnt++;
    report_and_stop();
  end
endmodule
